// >>> include/wdtrc_pkg.sv
package wdtrc_pkg;
    // ----------------------------------------
    // register byte addresses
    // ----------------------------------------
    localparam logic [3:0] ADDR_WDT_CTRL  = 4'h0;
    localparam logic [3:0] ADDR_RST_FLAGS = 4'h4;
    localparam logic [3:0] ADDR_LV_KEY    = 4'h8;
    localparam logic [3:0] ADDR_LV_WIDTH  = 4'hC;

    // ----------------------------------------
    // reset values and codes
    // ----------------------------------------
    localparam logic [7:0] WDT_CTRL_POR = 8'h53;
    localparam logic [7:0] LV_KEY_POR   = 8'h66;
    localparam logic [1:0] LV_WIDTH_POR = 2'h1;
    localparam logic [4:0] KEY_DISABLE  = 5'h15;
    localparam logic [4:0] KEY_ENABLE   = 5'h0A;
    localparam logic [7:0] LV_CODE0     = 8'h66;
    localparam logic [7:0] LV_CODE1     = 8'h55;
    localparam logic [7:0] LV_CODE2     = 8'h33;
    localparam logic [7:0] LV_CODE3     = 8'h99;
    localparam logic [7:0] LV_CODE4     = 8'hAA;
    localparam logic [7:0] LV_CODE5     = 8'hF0;
    localparam logic [7:0] PORT_POR     = 8'hFF;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int KEY_LSB      = 3;
    localparam int FLAG_WDT_KEY = 0;
    localparam int FLAG_LV_KEY  = 1;
    localparam int FLAG_LOWV    = 2;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CNT_W        = 19;
    localparam int FILT_W       = 8;
    localparam int KEY_DELAY_W  = 8;
    localparam logic [7:0] KEY_DELAY_DEF = 8'h04;
    localparam logic [7:0] LV_WIDTH0 = 8'h07;
    localparam logic [7:0] LV_WIDTH1 = 8'h1F;
    localparam logic [7:0] LV_WIDTH2 = 8'h3F;
    localparam logic [7:0] LV_WIDTH3 = 8'h7F;
    localparam int OVF_BIT0     = 8;
    localparam int OVF_BIT1     = 10;
    localparam int OVF_BIT2     = 12;
    localparam int OVF_BIT3     = 14;
    localparam int OVF_BIT_BASE = 11;

    typedef enum logic [1:0] {
        WDTRC_RUN,
        WDTRC_KEY_WAIT
    } wdtrc_state_t;
endpackage

// >>> core/wdtrc_lowv_filter.sv
module wdtrc_lowv_filter (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              srst,
    // control
    input  wire logic                              lircTick,
    input  wire logic                              active,
    input  wire logic                              lowSupply,
    input  wire logic [1:0]                        widthSel,
    // result
    output logic                                   qualified
);
    typedef struct packed {
        logic [wdtrc_pkg::FILT_W-1:0] cnt;
        logic                         hit;
    } wdtrc_filt_t;

    wdtrc_filt_t s_q, s_d;
    logic [wdtrc_pkg::FILT_W-1:0] limit;

    always_comb begin
        if (widthSel == 2'h0) begin
            limit = wdtrc_pkg::LV_WIDTH0;
        end else if (widthSel == 2'h1) begin
            limit = wdtrc_pkg::LV_WIDTH1;
        end else if (widthSel == 2'h2) begin
            limit = wdtrc_pkg::LV_WIDTH2;
        end else begin
            limit = wdtrc_pkg::LV_WIDTH3;
        end
    end

    // count whole slow periods of low supply; a pulse shorter than limit drops out
    always_comb begin
        s_d = s_q;
        s_d.hit = 1'b0;
        if (!active || !lowSupply) begin
            s_d.cnt = '0;
        end else if (lircTick) begin
            if (s_q.cnt >= limit) begin
                s_d.hit = 1'b1;
                s_d.cnt = '0;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign qualified = s_q.hit;
endmodule // wdtrc_lowv_filter

// >>> core/wdtrc_top.sv
// Overview of operation
// - counter advances on slow oscillator ticks
// - period select picks power-of-two timeout
// - key 10101 disables, 01010 enables, else reset
// - illegal key reset sets flag bit 0
// - key flag cleared only by software zero
// - key field powers up as 01010
// - running overflow resets device, sets timeout flag
// - sleeping overflow sets both flags, wakes core
// - key reset, clear instr, halt clear counter
// - power-on forces program counter to zero
// - power-on sets port registers all ones
// - low-voltage monitor active in fast/slow mode
// - monitor disabled in sleep or idle
// - short low-supply pulses are ignored
// - qualified low-voltage reset sets flag bit 2
// - invalid level key resets and reloads register
// - invalid level key reset sets flag bit 1
// - genuine low-voltage reset keeps level key
// - level key powers up as 01100110
// - flag register bits 7..3 read zero
// - width select picks 8/32/64/128 periods
// - low-voltage reset keeps timeout, power-down flags
// - halt clears counter; runs only if enabled
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
module wdtrc_top #(
    parameter logic [7:0] KEY_DELAY = wdtrc_pkg::KEY_DELAY_DEF
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // core events
    input  wire logic        lircTick,
    input  wire logic        clearInstr,
    input  wire logic        haltInstr,
    input  wire logic        wakeOther,
    input  wire logic        lowSupply,
    // reset network
    output logic             deviceReset,
    output logic             pcSpReset,
    output logic             wakeUp,
    output logic             timeoutFlag,
    output logic             powerdownFlag,
    output logic             sleeping,
    output logic [7:0]       portDataReset,
    output logic [7:0]       portDirReset,
    output logic             pcZero
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]                 wdtCtrl;
        logic [2:0]                 flags;
        logic [7:0]                 lvKey;
        logic [1:0]                 lvWidth;
        logic [wdtrc_pkg::CNT_W-1:0] cnt;
        wdtrc_pkg::wdtrc_state_t    wdtSt;
        logic [7:0]                 wdtDly;
        wdtrc_pkg::wdtrc_state_t    lvSt;
        logic [7:0]                 lvDly;
        logic                       sleep;
        logic                       toFlag;
        logic                       pdFlag;
        logic                       devRst;
        logic                       pcSp;
        logic                       wake;
        logic                       pcz;
        logic [7:0]                 portVal;
        logic                       ack;
        logic [31:0]                rdat;
    } wdtrc_state_s_t;

    wdtrc_state_s_t s_q, s_d;
    logic lvHit;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic lvCodeOk(input logic [7:0] v);
        return v == wdtrc_pkg::LV_CODE0 || v == wdtrc_pkg::LV_CODE1 ||
               v == wdtrc_pkg::LV_CODE2 || v == wdtrc_pkg::LV_CODE3 ||
               v == wdtrc_pkg::LV_CODE4 || v == wdtrc_pkg::LV_CODE5;
    endfunction

    function automatic logic wdtKeyOk(input logic [7:0] ctrl);
        logic [4:0] k;
        k = ctrl[7:wdtrc_pkg::KEY_LSB];
        return k == wdtrc_pkg::KEY_DISABLE || k == wdtrc_pkg::KEY_ENABLE;
    endfunction

    // one-hot register select shared by the read and write paths
    function automatic logic [3:0] regSel(input logic [3:0] adr);
        logic [3:0] s;
        s = 4'h0;
        if (adr == wdtrc_pkg::ADDR_WDT_CTRL) begin
            s = 4'h1;
        end else if (adr == wdtrc_pkg::ADDR_RST_FLAGS) begin
            s = 4'h2;
        end else if (adr == wdtrc_pkg::ADDR_LV_KEY) begin
            s = 4'h4;
        end else if (adr == wdtrc_pkg::ADDR_LV_WIDTH) begin
            s = 4'h8;
        end
        return s;
    endfunction

    // index of the counter bit whose rise marks overflow
    function automatic int unsigned ovfBit(input logic [2:0] sel);
        int unsigned b;
        b = wdtrc_pkg::OVF_BIT0;
        if (sel == 3'h0) begin
            b = wdtrc_pkg::OVF_BIT0;
        end else if (sel == 3'h1) begin
            b = wdtrc_pkg::OVF_BIT1;
        end else if (sel == 3'h2) begin
            b = wdtrc_pkg::OVF_BIT2;
        end else if (sel == 3'h3) begin
            b = wdtrc_pkg::OVF_BIT3;
        end else begin
            b = wdtrc_pkg::OVF_BIT_BASE + 32'(sel);
        end
        return b;
    endfunction

    // ----------------------------------------
    // low-voltage qualification
    // ----------------------------------------
    // held off in sleep and while a deviceReset pulse is out
    wdtrc_lowv_filter u_filt (
        .clk       (clk),
        .srst      (srst),
        .lircTick  (lircTick),
        .active    (!s_q.sleep && !s_q.devRst),
        .lowSupply (lowSupply),
        .widthSel  (s_q.lvWidth),
        .qualified (lvHit)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic       wr;
        logic       rd;
        logic       enabled;
        logic       ovf;
        logic [7:0] wv;
        int unsigned ob;
        logic [3:0] rs;
        wr = 1'b0;
        rd = 1'b0;
        enabled = 1'b0;
        ovf = 1'b0;
        wv = '0;
        ob = 0;
        rs = regSel(wb_adr_i);
        s_d = s_q;
        s_d.devRst = 1'b0;
        s_d.pcSp = 1'b0;
        s_d.wake = 1'b0;
        s_d.pcz = 1'b0;
        s_d.ack = 1'b0;

        // bus: one wait state, ack dropped the cycle after it
        wr = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack;
        rd = wb_cyc_i && wb_stb_i && !wb_we_i && !s_q.ack;
        wv = wb_dat_i[7:0];
        if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
            s_d.ack = 1'b1;
        end
        if (rd) begin
            s_d.rdat = '0;
            if (rs[0]) begin
                s_d.rdat[7:0] = s_q.wdtCtrl;
            end else if (rs[1]) begin
                s_d.rdat[2:0] = s_q.flags;
            end else if (rs[2]) begin
                s_d.rdat[7:0] = s_q.lvKey;
            end else if (rs[3]) begin
                s_d.rdat[1:0] = s_q.lvWidth;
            end
        end
        if (wr && wb_sel_i[0]) begin
            if (rs[0]) begin
                s_d.wdtCtrl = wv;
            end else if (rs[1]) begin
                // software can only clear; hardware sets below win
                s_d.flags = s_q.flags & wv[2:0];
            end else if (rs[2]) begin
                s_d.lvKey = wv;
            end else if (rs[3]) begin
                s_d.lvWidth = wv[1:0];
            end
        end

        // watchdog counter
        enabled = s_q.wdtCtrl[7:wdtrc_pkg::KEY_LSB] == wdtrc_pkg::KEY_ENABLE;
        ob = ovfBit(s_q.wdtCtrl[2:0]);
        if (clearInstr || haltInstr) begin
            s_d.cnt = '0;
        end else if (enabled && lircTick) begin
            s_d.cnt = s_q.cnt + 1'b1;
            ovf = s_d.cnt[ob];
        end
        if (clearInstr) begin
            s_d.pdFlag = 1'b0;
            s_d.toFlag = 1'b0;
        end
        if (haltInstr) begin
            s_d.sleep = 1'b1;
            s_d.pdFlag = 1'b1;
            s_d.toFlag = 1'b0;
        end else if (wakeOther) begin
            s_d.sleep = 1'b0;
        end
        if (ovf) begin
            s_d.cnt = '0;
            s_d.toFlag = 1'b1;
            if (s_q.sleep) begin
                // registers keep their values; only pc and stack restart
                s_d.pdFlag = 1'b1;
                s_d.pcSp = 1'b1;
                s_d.wake = 1'b1;
                s_d.sleep = 1'b0;
            end else begin
                s_d.devRst = 1'b1;
                s_d.pcz = 1'b1;
                s_d.portVal = wdtrc_pkg::PORT_POR;
                s_d.wdtCtrl = wdtrc_pkg::WDT_CTRL_POR;
                s_d.lvKey = wdtrc_pkg::LV_KEY_POR;
                s_d.lvWidth = wdtrc_pkg::LV_WIDTH_POR;
            end
        end

        // illegal watchdog key: delayed reset
        case (s_q.wdtSt)
            wdtrc_pkg::WDTRC_RUN: begin
                if (!wdtKeyOk(s_q.wdtCtrl)) begin
                    s_d.wdtSt = wdtrc_pkg::WDTRC_KEY_WAIT;
                    s_d.wdtDly = '0;
                    s_d.cnt = '0;
                end
            end
            default: begin
                if (lircTick) begin
                    s_d.wdtDly = s_q.wdtDly + 1'b1;
                end
                if (s_q.wdtDly >= KEY_DELAY) begin
                    s_d.wdtSt = wdtrc_pkg::WDTRC_RUN;
                    s_d.flags[wdtrc_pkg::FLAG_WDT_KEY] = 1'b1;
                    s_d.wdtCtrl = wdtrc_pkg::WDT_CTRL_POR;
                    s_d.devRst = 1'b1;
                    s_d.pcz = 1'b1;
                    s_d.cnt = '0;
                end
            end
        endcase

        // illegal level key: delayed reset, key reloaded
        case (s_q.lvSt)
            wdtrc_pkg::WDTRC_RUN: begin
                if (!lvCodeOk(s_q.lvKey)) begin
                    s_d.lvSt = wdtrc_pkg::WDTRC_KEY_WAIT;
                    s_d.lvDly = '0;
                end
            end
            default: begin
                if (lircTick) begin
                    s_d.lvDly = s_q.lvDly + 1'b1;
                end
                if (s_q.lvDly >= KEY_DELAY) begin
                    s_d.lvSt = wdtrc_pkg::WDTRC_RUN;
                    s_d.lvKey = wdtrc_pkg::LV_KEY_POR;
                    s_d.flags[wdtrc_pkg::FLAG_LV_KEY] = 1'b1;
                    s_d.devRst = 1'b1;
                    s_d.pcz = 1'b1;
                end
            end
        endcase

        // genuine low voltage: key and TO/POWERDOWN_FLAG untouched
        if (lvHit) begin
            s_d.flags[wdtrc_pkg::FLAG_LOWV] = 1'b1;
            s_d.devRst = 1'b1;
            s_d.pcz = 1'b1;
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            // every field named, so power-on state never leans on a default
            s_q.wdtCtrl <= wdtrc_pkg::WDT_CTRL_POR;
            s_q.flags <= '0;
            s_q.lvKey <= wdtrc_pkg::LV_KEY_POR;
            s_q.lvWidth <= wdtrc_pkg::LV_WIDTH_POR;
            s_q.cnt <= '0;
            s_q.wdtSt <= wdtrc_pkg::WDTRC_RUN;
            s_q.wdtDly <= '0;
            s_q.lvSt <= wdtrc_pkg::WDTRC_RUN;
            s_q.lvDly <= '0;
            s_q.sleep <= 1'b0;
            s_q.toFlag <= 1'b0;
            s_q.pdFlag <= 1'b0;
            s_q.devRst <= 1'b0;
            s_q.pcSp <= 1'b0;
            s_q.wake <= 1'b0;
            s_q.pcz <= 1'b1;
            s_q.portVal <= wdtrc_pkg::PORT_POR;
            s_q.ack <= 1'b0;
            s_q.rdat <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign wb_dat_o = s_q.rdat;
    assign wb_ack_o = s_q.ack;
    assign deviceReset = s_q.devRst;
    assign pcSpReset = s_q.pcSp;
    assign wakeUp = s_q.wake;
    assign timeoutFlag = s_q.toFlag;
    assign powerdownFlag = s_q.pdFlag;
    assign sleeping = s_q.sleep;
    assign portDataReset = s_q.portVal;
    assign portDirReset = s_q.portVal;
    assign pcZero = s_q.pcz;
endmodule // wdtrc_top

// >>> tb/wdtrc_monitor.sv
module wdtrc_monitor (
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // events and reset network
    input wire logic        clearInstr,
    input wire logic        haltInstr,
    input wire logic        deviceReset,
    input wire logic        pcSpReset,
    input wire logic        wakeUp,
    input wire logic        timeoutFlag,
    input wire logic        powerdownFlag,
    input wire logic        sleeping,
    input wire logic [7:0]  portDataReset,
    input wire logic [7:0]  portDirReset,
    input wire logic        pcZero
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a single cycle after request");
    flag_upper_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h4 |->
        wb_dat_o[31:3] == '0) else $error("flag register upper bits not zero");
    pc_zero_a: assert property (deviceReset |-> ##[0:1] pcZero)
        else $error("device reset without program counter clear");
    wake_pair_a: assert property (pcSpReset |-> wakeUp && !deviceReset)
        else $error("sleep overflow not a pure wake reset");
    sleep_flags_a: assert property (pcSpReset |-> ##[0:1] timeoutFlag && powerdownFlag)
        else $error("sleep overflow flags wrong");
    halt_flags_a: assert property (haltInstr |-> ##[1:2] powerdownFlag && !timeoutFlag && sleeping)
        else $error("halt did not set sleep state");
    clear_flags_a: assert property (clearInstr |-> ##[1:2] !timeoutFlag && !powerdownFlag)
        else $error("clear instruction left flags set");
    port_ones_a: assert property (portDataReset == 8'hFF && portDirReset == 8'hFF)
        else $error("port reset values not all ones");
    asleep_quiet_a: assert property ($past(sleeping) && sleeping |-> !deviceReset)
        else $error("device reset while asleep");

    cover property (pcSpReset);
    cover property (deviceReset && timeoutFlag);
    cover property (wb_ack_o && wb_we_i);
endmodule // wdtrc_monitor

bind wdtrc_top wdtrc_monitor wdtrc_monitor_i (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .clearInstr, .haltInstr, .deviceReset, .pcSpReset, .wakeUp,
    .timeoutFlag, .powerdownFlag, .sleeping, .portDataReset, .portDirReset, .pcZero);

// >>> tb/wdtrc_core_model.sv
module wdtrc_core_model #(
    parameter int TICK_DIV = 2
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // reset network
    input  wire logic deviceReset,
    input  wire logic pcSpReset,
    // slow oscillator and reset tally
    output logic      lircTick = 1'b0,
    output int        resetCount = 0
);
    timeunit 1ns;
    timeprecision 1ns;
    int div = 0;

    // slow oscillator runs free through resets, as the real one does
    always @(posedge clk) begin
        div <= (div == TICK_DIV - 1) ? 0 : div + 1;
        lircTick <= (div == TICK_DIV - 1);
        resetCount <= srst ? 0 : resetCount + int'(deviceReset) + int'(pcSpReset);
    end
endmodule // wdtrc_core_model

// >>> tb/wdtrc_top_tb.sv
module wdtrc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] KDLY = 8'h01;
    localparam int PCLR = 0, PHALT = 1, PWAKE = 2;
    localparam logic [7:0] LVC [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0};
    logic        clk = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        clearInstr = 1'b0, haltInstr = 1'b0, wakeOther = 1'b0, lowSupply = 1'b0;
    logic        wb_ack_o, lircTick, deviceReset, pcSpReset, wakeUp;
    logic        timeoutFlag, powerdownFlag, sleeping, pcZero;
    logic [7:0]  portDataReset, portDirReset, k;
    int          resetCount, badCount = 0, samplesChecked = 0, cycles = 0;
    int          seed, t, i, n0, lim;

    always #5 clk = ~clk;

    wdtrc_top #(.KEY_DELAY(KDLY)) wdtrc_top_i (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .lircTick, .clearInstr, .haltInstr,
        .wakeOther, .lowSupply, .deviceReset, .pcSpReset, .wakeUp, .timeoutFlag, .powerdownFlag,
        .sleeping, .portDataReset, .portDirReset, .pcZero);
    wdtrc_core_model #(.TICK_DIV(2)) wdtrc_core_model_i (.clk, .srst, .deviceReset, .pcSpReset,
        .lircTick, .resetCount);

    // ----------------------------------------
    // expectations and checks
    // ----------------------------------------
    function automatic int period(input int sel);
        return 1 << ((sel < 4) ? 8 + 2 * sel : 11 + sel);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkRange(input int got, input int lo, input int hi);
        samplesChecked++;
        if (got < lo || got > hi) begin
            badCount++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic endOfTest();
        $display("checks=%0d errors=%0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // drivers
    // ----------------------------------------
    task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        r = wb_dat_o;
        if (wb_ack_o !== 1'b1) begin
            badCount++;
            $display("[ERR] t=%0t ack=%h exp=%h", $time, wb_ack_o, 1'b1);
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        logic [31:0] r;
        bus(a, 1'b0, 8'h00, r);
        chk(r, {24'h0, e});
    endtask

    // one-cycle event pulse; only the chosen line is touched
    task automatic pulse(input int w);
        if (w == PCLR) clearInstr <= 1'b1;
        else if (w == PHALT) haltInstr <= 1'b1;
        else wakeOther <= 1'b1;
        @(posedge clk);
        if (w == PCLR) clearInstr <= 1'b0;
        else if (w == PHALT) haltInstr <= 1'b0;
        else wakeOther <= 1'b0;
    endtask

    // counts slow ticks until either reset output shows up
    task automatic waitRst(input int lim, output int tk);
        int n;
        tk = 0;
        for (n = 0; n < lim && deviceReset !== 1'b1 && pcSpReset !== 1'b1; n++) begin
            @(posedge clk);
            if (lircTick === 1'b1) tk++;
        end
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            badCount++;
            endOfTest();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = 22;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(wdtrc_pkg::ADDR_WDT_CTRL, 8'h53);
        rd(wdtrc_pkg::ADDR_LV_KEY, 8'h66);
        rd(wdtrc_pkg::ADDR_RST_FLAGS, 8'h00);
        wb_sel_i <= 4'h0;
        wr(wdtrc_pkg::ADDR_WDT_CTRL, 8'hA8);
        wb_sel_i <= 4'hF;
        rd(wdtrc_pkg::ADDR_WDT_CTRL, 8'h53);
        k = 8'($random(seed));
        wr(k[3:0] | 4'h1, k);
        rd(k[3:0] | 4'h1, 8'h00);
        for (i = 0; i < 8; i++) begin
            wr(wdtrc_pkg::ADDR_WDT_CTRL, {5'h15, 3'(i)});
            rd(wdtrc_pkg::ADDR_WDT_CTRL, {5'h15, 3'(i)});
        end
        wr(wdtrc_pkg::ADDR_WDT_CTRL, 8'hA8);
        n0 = resetCount;
        repeat (600) @(posedge clk);
        chk(resetCount, n0);
        for (i = 0; i < 4; i++) begin
            wr(wdtrc_pkg::ADDR_WDT_CTRL, {5'h0A, 3'(i)});
            repeat (period(i)) @(posedge clk);
            pulse(PCLR);
            waitRst(4 * period(i), t);
            chk(deviceReset, 1'b1);
            chkRange(t, period(i) - 1, period(i) + 1);
            repeat (2) @(posedge clk);
            chk(timeoutFlag, 1'b1);
        end
        wr(wdtrc_pkg::ADDR_WDT_CTRL, 8'hA8);
        wr(wdtrc_pkg::ADDR_LV_KEY, 8'h55);
        for (i = 0; i < 4; i++) begin
            wr(wdtrc_pkg::ADDR_LV_WIDTH, 8'(i));
            lim = (i == 0) ? 8 : 16 << i;
            n0 = resetCount;
            lowSupply <= 1'b1;
            repeat (lim) @(posedge clk);
            lowSupply <= 1'b0;
            repeat (4) @(posedge clk);
            chk(resetCount, n0);
            lowSupply <= 1'b1;
            waitRst(600, t);
            lowSupply <= 1'b0;
            chkRange(t, lim - 1, lim + 1);
            rd(wdtrc_pkg::ADDR_RST_FLAGS, 8'h04);
            wr(wdtrc_pkg::ADDR_RST_FLAGS, 8'h00);
        end
        rd(wdtrc_pkg::ADDR_LV_KEY, 8'h55);
        chk({timeoutFlag, powerdownFlag}, 2'b10);
        do k = 8'($random(seed)); while (k[4:0] == 5'h15 || k[4:0] == 5'h0A);
        wr(wdtrc_pkg::ADDR_WDT_CTRL, {k[4:0], 3'h0});
        waitRst(40, t);
        chkRange(t, KDLY, KDLY + 2);
        rd(wdtrc_pkg::ADDR_RST_FLAGS, 8'h01);
        rd(wdtrc_pkg::ADDR_WDT_CTRL, 8'h53);
        wr(wdtrc_pkg::ADDR_RST_FLAGS, 8'hFF);
        rd(wdtrc_pkg::ADDR_RST_FLAGS, 8'h01);
        wr(wdtrc_pkg::ADDR_RST_FLAGS, 8'h00);
        rd(wdtrc_pkg::ADDR_RST_FLAGS, 8'h00);
        n0 = resetCount;
        for (i = 0; i < 6; i++) begin
            wr(wdtrc_pkg::ADDR_LV_KEY, LVC[i]);
            rd(wdtrc_pkg::ADDR_LV_KEY, LVC[i]);
        end
        chk(resetCount, n0);
        do k = 8'($random(seed)); while (k inside {LVC});
        wr(wdtrc_pkg::ADDR_LV_KEY, k);
        waitRst(40, t);
        chk(deviceReset, 1'b1);
        rd(wdtrc_pkg::ADDR_LV_KEY, 8'h66);
        rd(wdtrc_pkg::ADDR_RST_FLAGS, 8'h02);
        wr(wdtrc_pkg::ADDR_WDT_CTRL, 8'h50);
        pulse(PHALT);
        lowSupply <= 1'b1;
        n0 = resetCount;
        waitRst(1000, t);
        lowSupply <= 1'b0;
        chk(pcSpReset, 1'b1);
        chkRange(t, 255, 257);
        repeat (3) @(posedge clk);
        chk(resetCount, n0 + 1);
        chk({timeoutFlag, powerdownFlag, sleeping}, 3'b110);
        pulse(PCLR);
        pulse(PHALT);
        pulse(PWAKE);
        repeat (2) @(posedge clk);
        chk({timeoutFlag, powerdownFlag, sleeping}, 3'b010);
        endOfTest();
    end
endmodule // wdtrc_top_tb
